// ### verif/host_model.sv
// host processor model on the control port: one-cycle strobes
// assumes ref_clk shared with the sequencer; tasks called by the bench
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic ref_clk,
    input wire logic seq_running_q,
    input wire logic host_rvalid_q,
    input wire logic [15:0] host_rdata_q,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_addr,
    output logic [15:0] host_wdata,
    output logic wait_spent
);
    initial begin
        wait_spent = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = 8'h00;
        host_wdata = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////
    // holds off while busy except for run control (0x6f) writes; rude pushes through to probe refusal
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input bit rude);
        int n;
        n = 0;
        while (!rude && a !== 8'h6f && seq_running_q !== 1'b0 && n < 5000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 5000) begin
            wait_spent <= 1'b1;
        end
        @(posedge ref_clk);
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge ref_clk);
        host_wr <= 1'b0;
        host_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        d = 16'hxxxx;
        @(posedge ref_clk);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge ref_clk);
        host_rd <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            if (host_rvalid_q === 1'b1) begin
                d = host_rdata_q;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// ### verif/tb_control_write_sequencer.sv
// bench for the control write sequencer with a host model
// assumes design files compiled first; short tick for speed
`timescale 1ns/1ps
`default_nettype none
module tb_control_write_sequencer;
    import seq_pkg::*;
    localparam int T = 8;
    logic ref_clk = 1'b0, rst_n = 1'b0, host_wr, host_rd, rvalid, refused;
    logic [7:0] host_addr, ctl_addr_q;
    logic [15:0] host_wdata, rdata, ctl_mask_q, ctl_data_q;
    logic step_load_we = 1'b0, ctl_wr_q, running, run_d = 1'b0, spent;
    logic [4:0] step_load_idx = 5'h00;
    logic [27:0] step_load_word = 28'h0000000;
    int bad_count = 0, checked = 0, cyc = 0, wr_n = 0, ref_n = 0, t_last = 0, t_prev = 0, t_fall = 0;
    always #2 ref_clk = ~ref_clk;
    control_write_sequencer #(.TICK_CYCLES(T)) control_write_sequencer_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata_q(rdata), .host_rvalid_q(rvalid), .host_refused_q(refused),
        .step_load_we(step_load_we), .step_load_idx(step_load_idx), .step_load_word(step_load_word),
        .ctl_wr_q(ctl_wr_q), .ctl_addr_q(ctl_addr_q), .ctl_mask_q(ctl_mask_q), .ctl_data_q(ctl_data_q),
        .seq_running_q(running));
    host_model host_model_i (.ref_clk(ref_clk), .seq_running_q(running), .host_rvalid_q(rvalid),
        .host_rdata_q(rdata), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
        .host_wdata(host_wdata), .wait_spent(spent));
    ////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cyc++;
        if (ctl_wr_q === 1'b1) begin
            wr_n++;
            t_prev = t_last;
            t_last = cyc;
        end
        if (refused === 1'b1) ref_n++;
        if (spent === 1'b1) begin
            bad_count++;
            close_out();
        end
        if (run_d === 1'b1 && running === 1'b0) t_fall = cyc;
        run_d = running;
    end
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_wr(input int n);
        for (int i = 0; i < 2000 && wr_n < n; i++) @(posedge ref_clk);
        if (wr_n < n) begin
            bad_count++;
            close_out();
        end
    endtask
    task automatic load(input logic [4:0] i, input logic [27:0] w);
        @(posedge ref_clk);
        step_load_we <= 1'b1;
        step_load_idx <= i;
        step_load_word <= w;
        @(posedge ref_clk);
        step_load_we <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [15:0] d;
        int n0;
        host_model_i.rd(8'h6f, d);
        chk(d, 16'h0000);
        host_model_i.rd(8'h70, d);
        chk(d, 16'h0000);
        n0 = wr_n;
        host_model_i.wr(8'h22, 16'h1234, 1'b0);
        wait_wr(n0 + 1);
        chk({ctl_addr_q, ctl_mask_q, ctl_data_q}, 40'h22_ffff_1234);
        $display("test reset done");
    endtask
    task automatic t_run();
        logic [15:0] d;
        int n0;
        n0 = wr_n;
        host_model_i.wr(8'h6f, 16'h0102, 1'b0);
        wait_wr(n0 + 1);
        chk(ctl_addr_q, 8'h12);
        chk(ctl_mask_q, 16'h00f0);
        chk(ctl_data_q, 16'h0050);
        host_model_i.rd(8'h70, d);
        chk(d[0], 1'b1);
        host_model_i.wr(8'h22, 16'h1234, 1'b1);
        repeat (3) @(posedge ref_clk);
        chk(ref_n, 1);
        wait_wr(n0 + 2);
        chk(t_last - t_prev, 9 * T);
        chk(ctl_addr_q, 8'h34);
        chk(ctl_mask_q, 16'hf000);
        chk(ctl_data_q, 16'hb000);
        repeat (12 * T) @(posedge ref_clk);
        chk(t_fall - t_last >= 10 * T - 4 && t_fall - t_last <= 10 * T + 2, 1);
        chk(wr_n, n0 + 2);
        host_model_i.rd(8'h6f, d);
        chk(d, 16'h0002);
        host_model_i.rd(8'h70, d);
        chk(d, 16'h0030);
        $display("test run done");
    endtask
    task automatic t_abort();
        logic [15:0] d;
        int n0;
        n0 = wr_n;
        host_model_i.wr(8'h6f, 16'h0102, 1'b0);
        wait_wr(n0 + 1);
        host_model_i.wr(8'h6f, 16'h0200, 1'b0);
        repeat (2) @(posedge ref_clk);
        chk(running, 1'b0);
        repeat (12 * T) @(posedge ref_clk);
        chk(wr_n, n0 + 1);
        host_model_i.rd(8'h6f, d);
        chk(d, 16'h0000);
        $display("test abort done");
    endtask
    task automatic t_rom();
        logic [15:0] d;
        int n0;
        n0 = wr_n;
        host_model_i.wr(8'h6f, 16'h0120, 1'b0);
        wait_wr(n0 + 1);
        chk({ctl_addr_q, ctl_mask_q, ctl_data_q}, 40'h00_0001_0000);
        repeat (10 * T) @(posedge ref_clk);
        host_model_i.rd(8'h6f, d);
        chk(d, 16'h0020);
        host_model_i.wr(8'h6f, 16'h0131, 1'b0);
        repeat (20) @(posedge ref_clk);
        chk({wr_n, running}, {n0 + 1, 1'b0});
        host_model_i.rd(8'h6f, d);
        chk(d, 16'h0031);
        $display("test rom done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(running, 1'b0);
        t_reset();
        load(5'd2, {1'b0, 4'h0, 3'd3, 4'd4, 8'h12, 8'hf5});
        load(5'd3, {1'b1, 4'h1, 3'd7, 4'd12, 8'h34, 8'hab});
        t_run();
        t_abort();
        t_rom();
        close_out();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        bad_count++;
        close_out();
    end
endmodule
`default_nettype wire

// ### verilog/control_write_sequencer.sv
// control write sequencer: run/status registers on the host control port,
// step fetch, masked field writes and per-step timing
// assumes host control port inputs synchronous to ref_clk; steps loaded over step_load_*
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"
module control_write_sequencer import seq_pkg::*; #(
    parameter int TICK_CYCLES = `STEP_UNIT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_addr,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata_q,
    output logic host_rvalid_q,
    output logic host_refused_q,
    input wire logic step_load_we,
    input wire logic [4:0] step_load_idx,
    input wire logic [`STEP_BITS-1:0] step_load_word,
    output logic ctl_wr_q,
    output logic [7:0] ctl_addr_q,
    output logic [15:0] ctl_mask_q,
    output logic [15:0] ctl_data_q,
    output logic seq_running_q
);
    generate
        if (TICK_CYCLES < 3 || TICK_CYCLES > 65535) begin : g_bad_tick
            $error("TICK_CYCLES out of range 3..65535");
        end
    endgenerate

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    localparam logic [15:0] TICK_END = 16'(TICK_CYCLES - 2);

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta_q, rst_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host port decode
    step_mem_if mem ();
    step_memory u_mem (.ref_clk(ref_clk), .rst_n(rst_q), .port(mem.mem));

    seq_state_t state_q, state_d;
    logic go_q, busy_q, last_q;
    logic [5:0] first_step_q, idx_q, last_acc_q;
    logic [15:0] pre_q, ticks_q, target_q;

    wire logic rc_hit = host_addr == `RUN_CTRL_ADDR;
    wire logic st_hit = host_addr == `RUN_STAT_ADDR;
    wire logic local_hit = rc_hit | st_hit;
    wire logic ctrl_wr = host_wr & rc_hit;
    wire logic abort_req = ctrl_wr & host_wdata[`ABORT_BIT];
    wire logic go_req = ctrl_wr & host_wdata[`GO_BIT];
    wire logic fwd_wr = host_wr & ~local_hit & ~busy_q;
    wire logic refuse_wr = host_wr & ~local_hit & busy_q;
    wire logic reserved_idx = idx_q > `ROM_TOP;
    wire logic wait_end = state_q == S_WAIT && ticks_q == target_q && pre_q == TICK_END;
    wire logic seq_done = (state_q == S_FETCH && reserved_idx) || (wait_end && last_q);
    // abort reads back as zero: it is an action, not a state
    wire logic [15:0] ctrl_view = {7'h00, go_q, 2'h0, first_step_q};
    wire logic [15:0] stat_view = {6'h00, last_acc_q, 3'h0, busy_q};

    ////////////////////////////////////////////////////////////////////////////
    // step decode
    wire step_t step = mem.rd_data;
    wire logic [7:0] width_mask = 8'hff >> (3'h7 - step.field_width);
    wire logic [7:0] value_used = step.value & width_mask; // RQ12
    wire logic [15:0] field_mask = {8'h00, width_mask} << step.field_lsb;
    wire logic [15:0] field_data = {8'h00, value_used} << step.field_lsb;
    wire logic [15:0] target_d = (16'h0001 << step.wait_code) + 16'(`WAIT_BASE);

    assign mem.rd_en = state_q == S_FETCH && !reserved_idx && !abort_req;
    assign mem.rd_idx = idx_q;
    assign mem.wr_en = step_load_we;
    assign mem.wr_idx = step_load_idx;
    assign mem.wr_data = step_t'(step_load_word);

    ////////////////////////////////////////////////////////////////////////////
    // sequence control
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (go_q && !abort_req) begin
                    state_d = S_FETCH; // RQ2
                end
            end
            S_FETCH: begin
                if (abort_req || reserved_idx) begin
                    state_d = S_IDLE; // RQ1 RQ5
                end else begin
                    state_d = S_ISSUE;
                end
            end
            S_ISSUE: begin
                state_d = abort_req ? S_IDLE : S_WAIT; // RQ1
            end
            S_WAIT: begin
                if (abort_req) begin
                    state_d = S_IDLE; // RQ1
                end else if (wait_end) begin
                    state_d = last_q ? S_IDLE : S_FETCH; // RQ3 RQ11 RQ13
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            state_q <= S_IDLE; // RQ14
            go_q <= 1'b0;
            busy_q <= 1'b0;
            first_step_q <= 6'h00;
        end else begin
            state_q <= state_d;
            busy_q <= state_d != S_IDLE; // RQ7 RQ13
            // a new go outlives the completion clear; abort overrides both
            go_q <= abort_req ? 1'b0 : go_req ? 1'b1 : seq_done ? 1'b0 : go_q; // RQ4 RQ1
            if (ctrl_wr) begin
                first_step_q <= host_wdata[`FIRST_MSB:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            idx_q <= 6'h00;
            last_acc_q <= 6'h00;
            last_q <= 1'b0;
            target_q <= 16'h0000;
        end else if (state_q == S_IDLE) begin
            idx_q <= first_step_q; // RQ2
        end else if (state_q == S_FETCH) begin
            last_acc_q <= idx_q; // RQ6
        end else if (state_q == S_ISSUE) begin
            idx_q <= idx_q + 6'h01; // RQ3
            last_q <= step.last; // RQ11
            target_q <= target_d - 16'h0001; // RQ10
        end
    end

    // the period counts from the issue cycle, so fetch latency is inside it
    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            pre_q <= 16'h0000;
            ticks_q <= 16'h0000;
        end else if (state_q == S_ISSUE) begin
            pre_q <= 16'h0001;
            ticks_q <= 16'h0000;
        end else if (pre_q == TICK_LAST) begin
            pre_q <= 16'h0000;
            ticks_q <= ticks_q + 16'h0001; // RQ10
        end else begin
            pre_q <= pre_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register write port and host answers
    wire logic step_wr = state_q == S_ISSUE && !abort_req;

    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            ctl_wr_q <= 1'b0;
            ctl_addr_q <= 8'h00;
            ctl_mask_q <= 16'h0000;
            ctl_data_q <= 16'h0000;
        end else begin
            ctl_wr_q <= step_wr | fwd_wr; // RQ8 RQ13
            if (step_wr) begin
                ctl_addr_q <= step.target_reg; // RQ9
                ctl_mask_q <= field_mask;
                ctl_data_q <= field_data;
            end else if (fwd_wr) begin
                ctl_addr_q <= host_addr;
                ctl_mask_q <= 16'hffff;
                ctl_data_q <= host_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            host_rdata_q <= 16'h0000;
            host_rvalid_q <= 1'b0;
            host_refused_q <= 1'b0;
        end else begin
            host_rvalid_q <= host_rd;
            host_refused_q <= refuse_wr; // RQ8
            if (host_rd) begin
                host_rdata_q <= rc_hit ? ctrl_view : st_hit ? stat_view : 16'h0000;
            end
        end
    end

    assign seq_running_q = busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    int since_issue_q;
    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            since_issue_q <= 0;
        end else begin
            since_issue_q <= (state_q == S_ISSUE) ? 1 : since_issue_q + 1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_q);

    abort_stops_a: assert property (abort_req |=> state_q == S_IDLE && !busy_q && !go_q ##1 !ctl_wr_q) // RQ1
        else $error("abort did not stop the sequence");
    go_starts_a: assert property (state_q == S_IDLE && go_q && !abort_req
        |=> state_q == S_FETCH && idx_q == $past(first_step_q)) // RQ2
        else $error("start did not fetch the first step");
    steps_chain_a: assert property (wait_end && !last_q && !abort_req |=> state_q == S_FETCH ##2 ctl_wr_q) // RQ3
        else $error("next step not executed");
    go_cleared_a: assert property (seq_done && !go_req && !abort_req |=> !go_q) // RQ4
        else $error("go not cleared at completion");
    reserved_skip_a: assert property (state_q == S_FETCH && reserved_idx |-> !mem.rd_en ##1 state_q == S_IDLE) // RQ5
        else $error("reserved index executed");
    last_index_a: assert property (state_q == S_FETCH |=> last_acc_q == $past(idx_q)) // RQ6
        else $error("accessed index not reported");
    busy_tracks_a: assert property (busy_q != $past(busy_q) // RQ7
        |-> (busy_q ? $past(go_q && !abort_req) : $past(abort_req || seq_done)))
        else $error("running flag wrong");
    host_blocked_a: assert property (refuse_wr && state_q != S_ISSUE |=> !ctl_wr_q && host_refused_q) // RQ8
        else $error("host write passed while running");
    field_write_a: assert property (step_wr |=> ctl_wr_q && ctl_addr_q == $past(step.target_reg)
        && (ctl_data_q & ~ctl_mask_q) == 16'h0000) // RQ9 RQ12
        else $error("step write malformed");
    step_period_a: assert property (wait_end |-> since_issue_q == (int'(target_q) + 1) * TICK_CYCLES - 2) // RQ10
        else $error("step period wrong");
    end_stops_a: assert property (wait_end && last_q && !go_req |=> state_q == S_IDLE ##1 !busy_q[*3]) // RQ11 RQ13
        else $error("sequence ran past the last step");

    start_c: cover property (state_q == S_IDLE ##1 state_q == S_FETCH);
    abort_c: cover property (busy_q && abort_req);
    done_c: cover property (wait_end && last_q);
    refuse_c: cover property (refuse_wr);
endmodule
`default_nettype wire

// ### verilog/seq_cfg.svh
// constants of the control write sequencer: register map, fields, timing
// assumes one 250 MHz clock; included by bare name from every design file except the interface
//
// Notes on behaviour
// (RQ1) a one written to abort stops the sequence at once; control returns to host
// (RQ2) a one written to go starts steps at the first step index
// (RQ3) steps run one after another until a step carrying the last flag
// (RQ4) the sequencer clears go itself when the sequence completes
// (RQ5) index 0-31 is ram, 32-48 is rom, 49-63 reserved for software
// (RQ6) read-only six-bit field gives the step location accessed most recently
// (RQ7) read-only running flag is one while a sequence executes, else zero
// (RQ8) while running, host control register writes are refused; host should not try
// (RQ9) each step writes a 1-8 bit field at a given lsb of a target register
// (RQ10) step period including execution is 62.5 us times (2^wait code + 8)
// (RQ11) the step with the last flag is the final one executed
// (RQ12) value bits above the field width are ignored
// (RQ13) after abort or completion: idle, running clear, no further step writes
// (RQ14) after reset: idle, running clear, go, abort, indices all zero
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH

`define RUN_CTRL_ADDR 8'h6f
`define RUN_STAT_ADDR 8'h70
`define ABORT_BIT 9
`define GO_BIT 8
`define FIRST_MSB 5
`define RAM_TOP 6'h1f
`define ROM_TOP 6'h30
`define RAM_DEPTH 32
`define ROM_COUNT 17
`define STEP_BITS 28
`define ROM_FILL 28'h8000000
`define WAIT_BASE 8
`define STEP_UNIT_NS 62500
`define CLK_MHZ 250
`define STEP_UNIT_CYC ((`STEP_UNIT_NS * `CLK_MHZ) / 1000)

`endif

// ### verilog/seq_pkg.sv
// types shared by the sequencer, its step memory and their carrier
// assumes seq_cfg.svh for the widths
`default_nettype none
`include "seq_cfg.svh"
package seq_pkg;
    typedef struct packed {
        logic last;
        logic [3:0] wait_code;
        logic [2:0] field_width;
        logic [3:0] field_lsb;
        logic [7:0] target_reg;
        logic [7:0] value;
    } step_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_FETCH = 4'h2,
        S_ISSUE = 4'h4,
        S_WAIT = 4'h8
    } seq_state_t;
endpackage
`default_nettype wire

// ### verilog/step_mem_if.sv
// carrier between the sequencer and its step memory
// assumes seq_pkg is compiled first
`timescale 1ns/1ps
`default_nettype none
interface step_mem_if;
    import seq_pkg::*;
    logic rd_en;
    logic [5:0] rd_idx;
    step_t rd_data;
    logic wr_en;
    logic [4:0] wr_idx;
    step_t wr_data;
    modport seq (output rd_en, output rd_idx, input rd_data, output wr_en, output wr_idx, output wr_data);
    modport mem (input rd_en, input rd_idx, output rd_data, input wr_en, input wr_idx, input wr_data);
endinterface
`default_nettype wire

// ### verilog/step_memory.sv
// step store: 32 host-loaded ram steps, 17 rom steps, registered read
// assumes the reset already synchronised by the sequencer top
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"
module step_memory import seq_pkg::*; #(
    parameter logic [`ROM_COUNT*`STEP_BITS-1:0] ROM_IMAGE = {`ROM_COUNT{`ROM_FILL}}
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    step_mem_if.mem port
);
    step_t ram [`RAM_DEPTH];
    step_t rd_q;
    wire logic in_ram = port.rd_idx <= `RAM_TOP;
    wire logic [5:0] rom_idx = port.rd_idx - 6'h20;
    // rom image is a parameter so a product build can set its own sequences
    wire step_t rom_word = ROM_IMAGE[rom_idx * `STEP_BITS +: `STEP_BITS];
    wire step_t sel_word = in_ram ? ram[port.rd_idx[4:0]] : rom_word;

    always_ff @(posedge ref_clk) begin
        if (port.wr_en) begin
            ram[port.wr_idx] <= port.wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else if (port.rd_en) begin
            rd_q <= sel_word;
        end
    end

    assign port.rd_data = rd_q;
endmodule
`default_nettype wire
